//--- pkg/crs_pkg.sv
// Package: constants for the clock and reset sequencer.
// Assumes one clock (the oscillator clock) at 250 MHz, 4 ns period.
package crs_pkg;
  localparam int unsigned LockCycles    = 131072;
  localparam int unsigned WdogCycles    = 512;
  localparam int unsigned BusDlyCycles  = 32;
  localparam int unsigned BootHoldCyc   = 200;
  localparam int unsigned ExtRstMinCyc  = 8;
  localparam int unsigned MulWidth      = 16;
  localparam int unsigned DivWidth      = 2;
  localparam int unsigned BootWidth     = 4;
  localparam logic [15:0] MulReset      = 16'h0000;
  localparam logic [1:0]  ClkOutDivRst  = 2'h0;
  // Clock select codes: system clock as a multiple of oscillator
  localparam logic [2:0]  SelDiv2       = 3'h0;
  localparam logic [2:0]  SelX1         = 3'h1;
  localparam logic [2:0]  SelX2         = 3'h2;
  localparam logic [2:0]  SelX4         = 3'h3;
  localparam logic [15:0] MulCodeX2     = 16'h0004;
  localparam logic [15:0] MulCodeX4     = 16'h0008;
  typedef enum logic [1:0] {StReset, StBusWait, StRun, StLock} crs_state_t;
endpackage

//--- hw/crs_counter.sv
// Down counter used for lock-up and reset intervals.
// Assumes same clock and reset as the sequencer.
`timescale 1ns/1ps
module crs_counter #(
  parameter int unsigned Width = 18
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [Width-1:0] loadVal,
  output logic                  done
);
  logic [Width-1:0] cnt_q;
  logic [Width-1:0] cnt_d;
  logic             done_d;

  assign cnt_d  = load ? loadVal :
                  (cnt_q != '0) ? cnt_q - Width'(1) : cnt_q;
  assign done_d = !load && (cnt_q <= Width'(1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      done  <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      done  <= done_d;
    end
  end
endmodule

//--- hw/crs_sequencer.sv
// Clock and reset sequencer: lock-up phase, clock select, reset timing.
// Assumes all logic on the oscillator clock; reset and straps are async.
`timescale 1ns/1ps
module crs_sequencer #(
  parameter int unsigned LockCycles = crs_pkg::LockCycles,
  parameter int unsigned MulWidth   = crs_pkg::MulWidth
) (
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  input  wire logic                           external_reset_n,
  input  wire logic                           watchdogReset,
  input  wire logic                           mulWrite,
  input  wire logic [MulWidth-1:0]            mulData,
  input  wire logic [crs_pkg::DivWidth-1:0]   divWrData,
  input  wire logic                           divWrite,
  input  wire logic [crs_pkg::BootWidth-1:0]  bootPins,
  output logic [2:0]                          sysClkSel,
  output logic [crs_pkg::DivWidth-1:0]        clock_output_divider,
  output logic                                lockBusy,
  output logic                                coreReset_n,
  output logic                                busValid,
  output logic [crs_pkg::BootWidth-1:0]       bootMode,
  output logic                                bootValid
);
  // Counter wide enough for the longest interval
  localparam int unsigned MaxCyc = (LockCycles > crs_pkg::WdogCycles)
                                   ? LockCycles : crs_pkg::WdogCycles;
  localparam int unsigned CntW   = $clog2(MaxCyc + 1);

  logic                          rstS1_q;
  logic                          rstS2_q;
  logic [crs_pkg::BootWidth-1:0] bootS1_q;
  logic [crs_pkg::BootWidth-1:0] bootS2_q;
  logic [MulWidth-1:0]           mul_q;
  crs_pkg::crs_state_t           state_q;
  crs_pkg::crs_state_t           state_d;
  logic                          wdPend_q;
  logic                          cntLoad;
  logic [CntW-1:0]               cntVal;
  logic                          cntDone;
  logic [2:0]                    selNew;
  logic                          inReset;
  logic                          wdHit;
  logic                          wrOpen;
  logic                          clrRegs;
  logic                          bootTake;
  logic                          runNext;
  logic                          validNext;

  function automatic logic [2:0] decodeMul(input logic [MulWidth-1:0] m);
    if (m == MulWidth'(crs_pkg::MulCodeX4))
      decodeMul = crs_pkg::SelX4;
    else if (m == MulWidth'(crs_pkg::MulCodeX2))
      decodeMul = crs_pkg::SelX2;
    else if (m == '0)
      decodeMul = crs_pkg::SelDiv2;
    else
      decodeMul = crs_pkg::SelX1;
  endfunction

  // Two-stage synchroniser for the reset pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstS1_q <= 1'h0;
      rstS2_q <= 1'h0;
    end else begin
      rstS1_q <= external_reset_n;
      rstS2_q <= rstS1_q;
    end
  end

  // Two-stage synchroniser for the boot straps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bootS1_q <= '0;
      bootS2_q <= '0;
    end else begin
      bootS1_q <= bootPins;
      bootS2_q <= bootS1_q;
    end
  end

  // Reset low relies on supervisor pulse width of at least 8 cycles
  assign inReset = !rstS2_q;
  assign selNew  = decodeMul(mul_q);

  // Decodes shared by counter, state and register logic
  assign wdHit     = watchdogReset && state_q != crs_pkg::StReset;
  assign wrOpen    = state_q == crs_pkg::StRun
                     || state_q == crs_pkg::StLock;
  assign clrRegs   = inReset || wdHit;
  assign bootTake  = state_q == crs_pkg::StReset
                     && state_d == crs_pkg::StBusWait;
  assign runNext   = state_d == crs_pkg::StRun;
  assign validNext = runNext || state_d == crs_pkg::StLock;

  // Interval counter loads: reset pin, then watchdog, then writes, then bus delay once the watchdog interval ends
  always_comb begin
    cntLoad = 1'h0;
    cntVal  = '0;
    if (inReset) begin
      cntLoad = 1'h1;
      cntVal  = CntW'(crs_pkg::BusDlyCycles);
    end else if (wdHit) begin
      cntLoad = 1'h1;
      cntVal  = CntW'(crs_pkg::WdogCycles - 1);
    end else if (mulWrite && wrOpen) begin
      cntLoad = 1'h1;
      cntVal  = CntW'(LockCycles - 1);
    end else if (state_q == crs_pkg::StReset && wdPend_q && cntDone) begin
      cntLoad = 1'h1;
      cntVal  = CntW'(crs_pkg::BusDlyCycles);
    end
  end

  crs_counter #(.Width(CntW)) uCnt (
    .clk     (clk),
    .arst_n  (arst_n),
    .load    (cntLoad),
    .loadVal (cntVal),
    .done    (cntDone)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      crs_pkg::StReset: begin
        if (!inReset && !wdPend_q)
          state_d = crs_pkg::StBusWait;
        else if (!inReset && cntDone)
          state_d = crs_pkg::StBusWait;
      end
      crs_pkg::StBusWait: begin
        if (cntDone && !cntLoad)
          state_d = crs_pkg::StRun;
      end
      crs_pkg::StRun: begin
        if (mulWrite)
          state_d = crs_pkg::StLock;
      end
      crs_pkg::StLock: begin
        if (cntDone && !cntLoad)
          state_d = crs_pkg::StRun;
      end
      default: state_d = crs_pkg::StReset;
    endcase
    // Any reset source overrides the normal flow
    if (clrRegs)
      state_d = crs_pkg::StReset;
  end

  // State and watchdog stretch request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= crs_pkg::StReset;
      wdPend_q <= 1'h0;
    end else begin
      state_q <= state_d;
      if (inReset)
        wdPend_q <= 1'h0;
      else if (wdHit)
        wdPend_q <= 1'h1;
      else if (state_d == crs_pkg::StBusWait)
        wdPend_q <= 1'h0;
    end
  end

  // Software fields, cleared by any reset, refused outside run and lock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mul_q                <= MulWidth'(crs_pkg::MulReset);
      clock_output_divider <= crs_pkg::ClkOutDivRst;
    end else if (clrRegs) begin
      mul_q                <= MulWidth'(crs_pkg::MulReset);
      clock_output_divider <= crs_pkg::ClkOutDivRst;
    end else if (wrOpen) begin
      if (mulWrite)
        mul_q <= mulData;
      if (divWrite)
        clock_output_divider <= divWrData;
    end
  end

  // Clock select and status outputs follow the next state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sysClkSel   <= crs_pkg::SelDiv2;
      lockBusy    <= 1'h0;
      coreReset_n <= 1'h0;
      busValid    <= 1'h0;
    end else begin
      sysClkSel   <= runNext ? selNew : crs_pkg::SelDiv2;
      lockBusy    <= (state_d == crs_pkg::StLock);
      coreReset_n <= (state_d != crs_pkg::StReset);
      busValid    <= validNext;
    end
  end

  // Straps held by board 200 cycles, sampled as reset ends, at entry to bus wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bootMode  <= '0;
      bootValid <= 1'h0;
    end else if (bootTake) begin
      bootMode  <= bootS2_q;
      bootValid <= 1'h1;
    end else if (state_d == crs_pkg::StReset) begin
      bootValid <= 1'h0;
    end
  end
endmodule

//--- bench/crs_chk.sv
// Checker for the clock and reset sequencer, bound to its ports.
// Assumes one clock domain and arst_n as the only async reset.
`timescale 1ns/1ps
module crs_chk #(
  parameter int unsigned LockCycles = crs_pkg::LockCycles
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        watchdogReset,
  input wire logic        mulWrite,
  input wire logic [15:0] mulData,
  input wire logic [2:0]  sysClkSel,
  input wire logic [1:0]  clock_output_divider,
  input wire logic        lockBusy,
  input wire logic        coreReset_n,
  input wire logic        busValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  int         lockCnt_q;
  int         rstCnt_q;
  logic [2:0] selExp_q;
  logic       wdog_q;
  wire  [2:0] selMap = mulData == crs_pkg::MulCodeX2 ? crs_pkg::SelX2 :
                       mulData == crs_pkg::MulCodeX4 ? crs_pkg::SelX4 :
                       mulData == 16'h0000 ? crs_pkg::SelDiv2 :
                       crs_pkg::SelX1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lockCnt_q <= 0;
      rstCnt_q  <= 0;
      selExp_q  <= crs_pkg::SelDiv2;
      wdog_q    <= 1'h0;
    end else begin
      lockCnt_q <= (!lockBusy || mulWrite) ? 0 : lockCnt_q + 1;
      rstCnt_q  <= coreReset_n ? 0 : rstCnt_q + 1;
      if (!coreReset_n) selExp_q <= crs_pkg::SelDiv2;
      else if (mulWrite && busValid) selExp_q <= selMap;
      if (watchdogReset && busValid) wdog_q <= 1'h1;
      else if (coreReset_n && !busValid) wdog_q <= 1'h0;
    end
  end
  lock_start_a: assert property (mulWrite && busValid |=>
    lockBusy && sysClkSel == crs_pkg::SelDiv2) else $error("lock not begun");
  lock_div2_a: assert property (lockBusy |->
    sysClkSel == crs_pkg::SelDiv2) else $error("clock not halved in lock");
  lock_len_a: assert property ($fell(lockBusy) && coreReset_n |->
    lockCnt_q >= LockCycles - 3 && lockCnt_q <= LockCycles + 2)
    else $error("lock length wrong");
  new_sel_a: assert property ($fell(lockBusy) && coreReset_n |->
    sysClkSel == selExp_q) else $error("clock select wrong after lock");
  rst_state_a: assert property (!coreReset_n [*2] |->
    sysClkSel == crs_pkg::SelDiv2 && !busValid &&
    clock_output_divider == crs_pkg::ClkOutDivRst) else $error("reset state");
  wdog_len_a: assert property ($rose(coreReset_n) && wdog_q |->
    rstCnt_q >= 508 && rstCnt_q <= 516) else $error("watchdog pulse length");
  bus_wait_a: assert property ($rose(coreReset_n) |->
    !busValid ##[24:36] $rose(busValid)) else $error("bus wait wrong");
  refuse_wr_a: assert property (mulWrite && !busValid |=>
    !$rose(lockBusy)) else $error("write taken in reset");
  cover property ($fell(lockBusy));
  cover property ($rose(coreReset_n) && wdog_q);
  cover property (mulWrite && lockBusy);
endmodule
bind crs_sequencer crs_chk #(.LockCycles(LockCycles)) chk_u (.*);

//--- bench/crs_board.sv
// Board reset supervisor and boot straps driving the sequencer.
// Assumes warm is a request pulse made at the falling clock edge.
`timescale 1ns/1ps
module crs_board (
  input  wire logic       clk,
  input  wire logic       warm,
  input  wire logic [3:0] bootSel,
  output logic            rstN,
  output logic [3:0]      pins
);
  int cnt = 0;
  always @(negedge clk) begin
    if (warm) cnt <= 0;
    else if (cnt < 300) cnt <= cnt + 1;
  end
  assign rstN = cnt >= 8;
  assign pins = cnt < 208 ? bootSel : ~bootSel;
endmodule

//--- bench/test_clock_reset_sequencer.sv
// Testbench for the clock and reset sequencer.
// Assumes crs_board supplies reset pin and straps; lock count set to 64.
`timescale 1ns/1ps
module test_clock_reset_sequencer;
  localparam int unsigned LockCyc = 64;
  logic        clk = 1'h0, arst_n = 1'h0, warm = 1'h0, watchdogReset = 1'h0;
  logic        mulWrite = 1'h0, divWrite = 1'h0;
  logic [15:0] mulData = 16'h0000;
  logic [1:0]  divWrData = 2'h0, clkOutDiv;
  logic [3:0]  bootSel = 4'hA, bootPins, bootMode;
  logic        extRst_n, lockBusy, coreReset_n, busValid, bootValid;
  logic [2:0]  sysClkSel;
  logic [15:0] rowMul [5] = '{16'h0004, 16'h0008, 16'h0000, 16'h0001,
                              16'hFFFF};
  logic [2:0]  rowSel [5] = '{crs_pkg::SelX2, crs_pkg::SelX4,
                   crs_pkg::SelDiv2, crs_pkg::SelX1, crs_pkg::SelX1};
  int          miscompares = 0, n_compared = 0, cyc = 0, n;
  always #2 clk = ~clk;
  crs_board board_u (.clk(clk), .warm(warm), .bootSel(bootSel),
    .rstN(extRst_n), .pins(bootPins));
  crs_sequencer #(.LockCycles(LockCyc)) dut_u (.clk(clk), .arst_n(arst_n),
    .external_reset_n(extRst_n), .watchdogReset(watchdogReset),
    .mulWrite(mulWrite), .mulData(mulData), .divWrData(divWrData),
    .divWrite(divWrite), .bootPins(bootPins), .sysClkSel(sysClkSel),
    .clock_output_divider(clkOutDiv), .lockBusy(lockBusy),
    .coreReset_n(coreReset_n), .busValid(busValid),
    .bootMode(bootMode), .bootValid(bootValid));
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? lockBusy : k == 1 ? busValid : coreReset_n;
  endfunction
  task automatic waitLvl(input int k, input logic lvl, output int c);
    c = 0;
    while (pick(k) !== lvl && c < 2000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 2000) miscompares++;
  endtask
  task automatic pulse(input int k);
    if (k == 0) mulWrite <= 1'h1;
    else if (k == 1) divWrite <= 1'h1;
    else if (k == 2) watchdogReset <= 1'h1;
    else warm <= 1'h1;
    @(negedge clk);
    if (k == 0) mulWrite <= 1'h0;
    else if (k == 1) divWrite <= 1'h0;
    else if (k == 2) watchdogReset <= 1'h0;
    else warm <= 1'h0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    check("sel", sysClkSel, crs_pkg::SelDiv2);
    check("div", clkOutDiv, crs_pkg::ClkOutDivRst);
    waitLvl(1, 1'h1, n);
    check("boot", bootMode, 4'hA);
    check("bootv", bootValid, 1'h1);
    for (int i = 0; i < 5; i++) begin
      mulData <= rowMul[i];
      pulse(0);
      check("lock", lockBusy, 1'h1);
      check("lockSel", sysClkSel, crs_pkg::SelDiv2);
      waitLvl(0, 1'h0, n);
      check("lockLen", n inside {[LockCyc-3:LockCyc+2]}, 1'h1);
      check("newSel", sysClkSel, rowSel[i]);
    end
    mulData <= 16'h0008;
    pulse(0);
    repeat (20) @(negedge clk);
    mulData <= 16'h0004;
    pulse(0);
    waitLvl(0, 1'h0, n);
    check("restart", n inside {[LockCyc-3:LockCyc+2]}, 1'h1);
    check("restartSel", sysClkSel, crs_pkg::SelX2);
    bootSel <= 4'h5;
    pulse(3);
    waitLvl(2, 1'h0, n);
    pulse(0);
    check("refused", lockBusy, 1'h0);
    waitLvl(2, 1'h1, n);
    waitLvl(1, 1'h1, n);
    check("busWait", n inside {[24:36]}, 1'h1);
    check("warmBoot", bootMode, 4'h5);
    check("warmSel", sysClkSel, crs_pkg::SelDiv2);
    divWrData <= 2'h3;
    pulse(1);
    check("divWr", clkOutDiv, 2'h3);
    pulse(2);
    waitLvl(2, 1'h0, n);
    waitLvl(2, 1'h1, n);
    check("wdogLen", n inside {[506:516]}, 1'h1);
    check("wdogDiv", clkOutDiv, crs_pkg::ClkOutDivRst);
    check("wdogSel", sysClkSel, crs_pkg::SelDiv2);
    complete_run();
  end
endmodule
